// >>> hw/acr_defines.svh
// Purpose: Constants for the converter control block.
// Assumes: 20 MHz system clock.
// Notes: Status and driver-enable cycle counts are derived from the times below.
`ifndef ACR_DEFINES_SVH
`define ACR_DEFINES_SVH

`define ACR_CLK_NS 50
`define ACR_STS_RISE_NS 200
`define ACR_STS_FALL_NS 600
`define ACR_EARLY_EN_NS 1200
`define ACR_STS_RISE_CYC ((`ACR_STS_RISE_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_STS_FALL_CYC ((`ACR_STS_FALL_NS + `ACR_CLK_NS - 1) / `ACR_CLK_NS)
`define ACR_EARLY_EN_CYC (`ACR_EARLY_EN_NS / `ACR_CLK_NS)

`define ACR_CONV12_CYC 240
`define ACR_CONV8_CYC 160

`define ACR_OFS_STATUS 8'h00
`define ACR_OFS_RESULT 8'h04
`define ACR_OFS_CTRL 8'h08

`define ACR_ST_ACTIVE 0
`define ACR_ST_BUSY 1
`define ACR_ST_VALID 2
`define ACR_ST_EIGHT 3
`define ACR_CT_START 0
`define ACR_CT_EIGHT 1

`define ACR_PIN_RST 6'h02
`define ACR_RESULT_RST 12'h000

`endif

// >>> hw/acr_pkg.sv
// Purpose: Types for the converter control block.
// Assumes: Nothing beyond the defines header.
// Notes: State codes are left to the tools.
package acr_pkg;
    typedef enum logic [1:0] {
        ACR_IDLE,
        ACR_CONV,
        ACR_TAIL
    } acr_state_t;
endpackage : acr_pkg

// >>> hw/acr_sar.sv
// Purpose: Successive-approximation sequencer, one bit per step.
// Assumes: Comparator high means input is at or above the trial code.
// Notes: Step must exceed comparator sync latency of about four cycles.
module acr_sar #(
    parameter int STEP12 = 20,
    parameter int STEP8 = 20
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_start,
    input wire logic i_eight,
    input wire logic i_cmp,
    output logic [11:0] o_dac_code,
    output logic [11:0] o_result,
    output logic o_done
);
    import acr_pkg::*;

    logic run_q, run_d;
    logic eight_q, eight_d;
    logic done_q, done_d;
    logic [3:0] bit_q, bit_d;
    logic [15:0] step_q, step_d;
    logic [11:0] code_q, code_d;
    logic [15:0] step_last;
    logic [3:0] bit_last;

    always_comb begin
        step_last = eight_q ? 16'(STEP8 - 1) : 16'(STEP12 - 1);
        bit_last = eight_q ? 4'h4 : 4'h0;
        run_d = run_q;
        eight_d = eight_q;
        bit_d = bit_q;
        step_d = step_q;
        code_d = code_q;
        done_d = 1'b0;
        if (i_start && !run_q) begin
            run_d = 1'b1;
            eight_d = i_eight;
            bit_d = 4'hB;
            step_d = 16'h0000;
            code_d = 12'h800;
        end else if (run_q) begin
            if (step_q == step_last) begin
                step_d = 16'h0000;
                if (!i_cmp) begin
                    code_d[bit_q] = 1'b0;
                end
                if (bit_q == bit_last) begin
                    run_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    bit_d = bit_q - 4'h1;
                    code_d[bit_q - 4'h1] = 1'b1;
                end
            end else begin
                step_d = step_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            run_q <= 1'b0;
            eight_q <= 1'b0;
            done_q <= 1'b0;
            bit_q <= 4'h0;
            step_q <= 16'h0000;
            code_q <= 12'h000;
        end else begin
            run_q <= run_d;
            eight_q <= eight_d;
            done_q <= done_d;
            bit_q <= bit_d;
            step_q <= step_d;
            code_q <= code_d;
        end
    end

    assign o_dac_code = code_q;
    assign o_result = code_q;
    assign o_done = done_q;
endmodule : acr_sar

// >>> hw/acr_ctrl.sv
// Purpose: Conversion start, status and result readout of a SAR converter.
// Assumes: Control pins are asynchronous; AHB-Lite on the system clock.
// Notes: Pin timing is counted from the cycle a start is taken.
//
// The address map and the AHB-Lite interface to the registers are this design's own decisions.
`include "acr_defines.svh"

// Behaviour
// - Pair of enable and select completing with read/convert low starts.
// - With both asserted, read/convert high reads, low converts.
// - Stand-alone: drive outputs while read/convert high; fall starts.
// - Low pulse: float on the fall, drive again when done.
// - Status rises 200 ns after start, falls 600 ns after data valid.
// - High pulse: drive while high, fall starts, float until next.
// - Starts during a running conversion cycle are ignored.
// - Status rises 200 ns after a conversion starts, falls 600 ns after it ends.
// - Data drivers may enable up to 1.2 us before status falls.
// - Byte address low at start: 12-bit; high: 8-bit conversion.
// - Read with byte address 0 enables MSB byte, 1 the LSB nibble.
// - Width pin low gives two bytes, high one 12-bit word.
// - Byte mode: bits 11..4 even, bits 3..0 upper nibble odd.
// - Enable low or select high: no operation, drivers float.
module acr_ctrl #(
    parameter int CONV12_CYCLES = `ACR_CONV12_CYC,
    parameter int CONV8_CYCLES = `ACR_CONV8_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_chip_en,
    input wire logic i_sel_n,
    input wire logic i_read_conv,
    input wire logic i_byte_addr_select,
    input wire logic i_width_12,
    input wire logic i_cmp,
    output logic [11:0] o_dac_code,
    output logic [11:0] o_db,
    output logic [11:0] o_db_oe,
    output logic o_conversion_active,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp
);
    import acr_pkg::*;

    // Pin synchronisers: three stages, filtered level follows agreement
    // Idle levels of the pins, so no false command edge follows reset
    localparam logic [5:0] PIN_RST = `ACR_PIN_RST;
    logic [5:0] pin_raw;
    logic [5:0] sync1_q, sync2_q, sync3_q, pin_q;

    assign pin_raw = {i_cmp, i_width_12, i_byte_addr_select, i_read_conv,
                      i_sel_n, i_chip_en};

    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_sync
            always_ff @(posedge i_clk_sys) begin
                if (i_srst) begin
                    sync1_q[gi] <= PIN_RST[gi];
                    sync2_q[gi] <= PIN_RST[gi];
                    sync3_q[gi] <= PIN_RST[gi];
                    pin_q[gi] <= PIN_RST[gi];
                end else begin
                    sync1_q[gi] <= pin_raw[gi];
                    sync2_q[gi] <= sync1_q[gi];
                    sync3_q[gi] <= sync2_q[gi];
                    if (sync2_q[gi] == sync3_q[gi]) begin
                        pin_q[gi] <= sync3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic ce, sel_n, rc, a0, w12, cmp;
    assign ce = pin_q[0];
    assign sel_n = pin_q[1];
    assign rc = pin_q[2];
    assign a0 = pin_q[3];
    assign w12 = pin_q[4];
    assign cmp = pin_q[5];

    // Control state
    acr_state_t state_q, state_d;
    logic [7:0] cnt_q, cnt_d;
    logic sts_q, sts_d;
    logic cmd_q, cmd_d;
    logic eight_q, eight_d;
    logic valid_q, valid_d;
    logic [11:0] result_q, result_d;
    logic [11:0] db_q, db_d;
    logic [11:0] oe_q, oe_d;
    logic sar_start;
    logic sar_done;
    logic [11:0] sar_result;
    logic conv_cmd, read_en, start_req, drive;
    logic soft_start, ctrl_eight_q, ctrl_eight_d;

    always_comb begin
        conv_cmd = ce && !sel_n && !rc;
        read_en = ce && !sel_n && rc;
        // Edge of the whole command, so whichever input completes it starts
        start_req = (conv_cmd && !cmd_q) || soft_start;
        state_d = state_q;
        cnt_d = cnt_q;
        sts_d = sts_q;
        cmd_d = conv_cmd;
        eight_d = eight_q;
        valid_d = valid_q;
        result_d = result_q;
        sar_start = 1'b0;
        case (state_q)
            ACR_IDLE: begin
                if (start_req) begin
                    state_d = ACR_CONV;
                    cnt_d = 8'h00;
                    eight_d = soft_start ? ctrl_eight_q : a0;
                    valid_d = 1'b0;
                    sar_start = 1'b1;
                end
            end
            ACR_CONV: begin
                if (cnt_q != 8'hFF) begin
                    cnt_d = cnt_q + 8'h01;
                end
                if (cnt_q == 8'(`ACR_STS_RISE_CYC - 1)) begin
                    sts_d = 1'b1;
                end
                if (sar_done) begin
                    result_d = eight_q ? {sar_result[11:4], 4'h0}
                                       : sar_result;
                    valid_d = 1'b1;
                    sts_d = 1'b1;
                    state_d = ACR_TAIL;
                    cnt_d = 8'h00;
                end
            end
            ACR_TAIL: begin
                cnt_d = cnt_q + 8'h01;
                // Data valid 600 ns ahead of status, inside the 1.2 us allowance
                if (cnt_q == 8'(`ACR_STS_FALL_CYC - 1)) begin
                    sts_d = 1'b0;
                    state_d = ACR_IDLE;
                end
            end
            default: begin
                state_d = ACR_IDLE;
            end
        endcase
        // Float while a result is pending so stale data never reaches the bus
        drive = read_en && valid_q;
        db_d = 12'h000;
        oe_d = 12'h000;
        if (drive) begin
            if (w12) begin
                db_d = result_q;
                oe_d = 12'hFFF;
            end else if (!a0) begin
                db_d = {result_q[11:4], 4'h0};
                oe_d = 12'hFF0;
            end else begin
                db_d = {result_q[3:0], 4'h0, 4'h0};
                oe_d = 12'hFF0;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            state_q <= ACR_IDLE;
            cnt_q <= 8'h00;
            sts_q <= 1'b0;
            cmd_q <= 1'b0;
            eight_q <= 1'b0;
            valid_q <= 1'b1;
            result_q <= `ACR_RESULT_RST;
            db_q <= 12'h000;
            oe_q <= 12'h000;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sts_q <= sts_d;
            cmd_q <= cmd_d;
            eight_q <= eight_d;
            valid_q <= valid_d;
            result_q <= result_d;
            db_q <= db_d;
            oe_q <= oe_d;
        end
    end

    acr_sar #(
        .STEP12(CONV12_CYCLES / 12),
        .STEP8(CONV8_CYCLES / 8)
    ) u_sar (
        .i_clk_sys(i_clk_sys),
        .i_srst(i_srst),
        .i_start(sar_start),
        .i_eight(eight_d),
        .i_cmp(cmp),
        .o_dac_code(o_dac_code),
        .o_result(sar_result),
        .o_done(sar_done)
    );

    // AHB-Lite slave, zero wait states, always OKAY
    logic wr_pend_q, wr_pend_d;
    logic [7:0] wr_addr_q, wr_addr_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic addr_phase;

    always_comb begin
        addr_phase = i_hsel && i_htrans[1] && i_hready;
        wr_pend_d = addr_phase && i_hwrite;
        wr_addr_d = addr_phase ? i_haddr[7:0] : wr_addr_q;
        hrdata_d = hrdata_q;
        soft_start = 1'b0;
        ctrl_eight_d = ctrl_eight_q;
        if (wr_pend_q && wr_addr_q == `ACR_OFS_CTRL) begin
            soft_start = i_hwdata[`ACR_CT_START];
            ctrl_eight_d = i_hwdata[`ACR_CT_EIGHT];
        end
        if (addr_phase && !i_hwrite) begin
            if (i_haddr[31:8] != 24'h000000) begin
                hrdata_d = 32'h0000_0000;
            end else if (i_haddr[7:0] == `ACR_OFS_STATUS) begin
                hrdata_d = 32'h0000_0000;
                hrdata_d[`ACR_ST_ACTIVE] = sts_q;
                hrdata_d[`ACR_ST_BUSY] = (state_q != ACR_IDLE);
                hrdata_d[`ACR_ST_VALID] = valid_q;
                hrdata_d[`ACR_ST_EIGHT] = eight_q;
            end else if (i_haddr[7:0] == `ACR_OFS_RESULT) begin
                hrdata_d = {20'h00000, result_q};
            end else if (i_haddr[7:0] == `ACR_OFS_CTRL) begin
                hrdata_d = 32'h0000_0000;
                hrdata_d[`ACR_CT_EIGHT] = ctrl_eight_q;
            end else begin
                hrdata_d = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            hrdata_q <= 32'h0000_0000;
            ctrl_eight_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            hrdata_q <= hrdata_d;
            ctrl_eight_q <= ctrl_eight_d;
        end
    end

    logic hreadyout_q, hresp_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q <= 1'b0;
        end
    end

    assign o_db = db_q;
    assign o_db_oe = oe_q;
    assign o_conversion_active = sts_q;
    assign o_hrdata = hrdata_q;
    assign o_hreadyout = hreadyout_q;
    assign o_hresp = hresp_q;
endmodule : acr_ctrl

// >>> test/acr_cmp_model.sv
// Purpose: Analog comparator in front of the SAR, seen as logic.
// Assumes: Input voltage given as an ideal 12-bit code.
// Notes: Settles at once; the design resynchronises it.
module acr_cmp_model (
    input wire logic [11:0] i_vin,
    input wire logic [11:0] i_dac_code,
    output logic o_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_cmp = (i_vin >= i_dac_code);
endmodule : acr_cmp_model

// >>> test/acr_ctrl_chk.sv
// Purpose: Port checks for the converter control block.
// Assumes: One clock, synchronous reset.
// Notes: Pin paths carry a few cycles of sync delay.
module acr_ctrl_chk #(
    parameter int CONV12_CYCLES = 240,
    parameter int CONV8_CYCLES = 160
) (
    input wire logic i_clk_sys,
    input wire logic i_srst,
    input wire logic i_chip_en,
    input wire logic i_sel_n,
    input wire logic [11:0] o_db,
    input wire logic [11:0] o_db_oe,
    input wire logic o_conversion_active
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LO = CONV8_CYCLES;
    localparam int HI = CONV12_CYCLES + 24;
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    oe_shape_a: assert property (
        o_db_oe inside {12'h000, 12'hFF0, 12'hFFF})
        else $error("driver enables not a legal format");
    float_zero_a: assert property ((o_db & ~o_db_oe) == 12'h000)
        else $error("undriven data line not zero");
    ce_idle_a: assert property (!i_chip_en [*8] |-> o_db_oe == 12'h000)
        else $error("drivers on with enable low");
    sel_idle_a: assert property (i_sel_n [*8] |-> o_db_oe == 12'h000)
        else $error("drivers on with select high");
    conv_float_a: assert property (
        $rose(o_conversion_active) |-> o_db_oe == 12'h000)
        else $error("drivers on at conversion start");
    sts_hold_a: assert property (
        $rose(o_conversion_active) |=> o_conversion_active [*8])
        else $error("status dropped early");
    conv_len_a: assert property (
        $rose(o_conversion_active) |-> ##[LO:HI] $fell(o_conversion_active))
        else $error("conversion length out of range");
    early_en_a: assert property (
        (o_conversion_active && o_db_oe != 12'h000) |-> ##[1:24]
        !o_conversion_active)
        else $error("drivers on too long before status fall");
    cover property ($rose(o_conversion_active));
    cover property (o_db_oe == 12'hFF0);
    cover property (o_db_oe == 12'hFFF);
endmodule : acr_ctrl_chk

bind acr_ctrl acr_ctrl_chk #(
    .CONV12_CYCLES(CONV12_CYCLES),
    .CONV8_CYCLES(CONV8_CYCLES)
) acr_ctrl_chk_inst (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_chip_en(i_chip_en),
    .i_sel_n(i_sel_n),
    .o_db(o_db),
    .o_db_oe(o_db_oe),
    .o_conversion_active(o_conversion_active)
);

// >>> test/tb.sv
// Purpose: Pin and bus tests of the converter control block.
// Assumes: Short conversion lengths, comparator model as analog side.
// Notes: Pin timing checked in ranges because of pin sync.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import acr_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b0;
    logic sel_n = 1'b1;
    logic rc = 1'b0;
    logic a0 = 1'b0;
    logic w12 = 1'b1;
    logic cmp;
    logic sts;
    logic [11:0] vin = 12'h000;
    logic [11:0] dac;
    logic [11:0] db;
    logic [11:0] dboe;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    int n_mismatch = 0;
    int check_count = 0;

    always #25 clk = ~clk;

    acr_ctrl #(.CONV12_CYCLES(72), .CONV8_CYCLES(48)) acr_ctrl_inst (
        .i_clk_sys(clk), .i_srst(srst), .i_chip_en(ce), .i_sel_n(sel_n),
        .i_read_conv(rc), .i_byte_addr_select(a0), .i_width_12(w12),
        .i_cmp(cmp), .o_dac_code(dac), .o_db(db), .o_db_oe(dboe),
        .o_conversion_active(sts), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready),
        .o_hrdata(hrdata), .o_hresp(hresp));
    acr_cmp_model acr_cmp_model_inst (
        .i_vin(vin), .i_dac_code(dac), .o_cmp(cmp));

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Single word transfer; caller enters just after a rising edge
    task automatic ahb(input logic wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask : ahb

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        ahb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd_chk

    task automatic pins(input logic c, s, r, a, input int n);
        ce <= c;
        sel_n <= s;
        rc <= r;
        a0 <= a;
        repeat (n) @(posedge clk);
    endtask : pins

    task automatic wait_sts(input logic v, output int n);
        n = 0;
        while (sts !== v && n < 400) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_sts

    task automatic db_chk(input logic [11:0] d, input logic [11:0] oe);
        chk({8'h00, db, dboe}, {8'h00, d, oe});
    endtask : db_chk

    initial begin
        logic [31:0] r;
        int n;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        rd_chk(32'h0, 32'h4);
        rd_chk(32'h100, 32'h0);
        ahb(1'b1, 32'h8, 32'h2, r);
        rd_chk(32'h8, 32'h2);
        ahb(1'b1, 32'h8, 32'h0, r);
        vin <= 12'hA5C;
        pins(1'b1, 1'b1, 1'b0, 1'b0, 6);
        pins(1'b1, 1'b0, 1'b0, 1'b0, 1);
        wait_sts(1'b1, n);
        chk(32'(n >= 3 && n <= 9), 32'h1);
        pins(1'b1, 1'b1, 1'b0, 1'b0, 6);
        pins(1'b1, 1'b0, 1'b0, 1'b0, 6);
        pins(1'b1, 1'b0, 1'b1, 1'b0, 6);
        db_chk(12'h000, 12'h000);
        wait_sts(1'b0, n);
        repeat (10) @(posedge clk);
        chk({31'h0, sts}, 32'h0);
        db_chk(12'hA5C, 12'hFFF);
        chk({20'h00000, db & dboe}, 32'h0000_0A5C);
        w12 <= 1'b0;
        pins(1'b1, 1'b0, 1'b1, 1'b0, 8);
        db_chk(12'hA50, 12'hFF0);
        pins(1'b1, 1'b0, 1'b1, 1'b1, 8);
        db_chk(12'hC00, 12'hFF0);
        pins(1'b0, 1'b0, 1'b1, 1'b0, 8);
        db_chk(12'h000, 12'h000);
        pins(1'b1, 1'b1, 1'b1, 1'b0, 8);
        db_chk(12'h000, 12'h000);
        rd_chk(32'h4, 32'hA5C);
        rd_chk(32'h4, 32'hA5C);
        vin <= 12'h3E7;
        pins(1'b0, 1'b0, 1'b0, 1'b1, 6);
        pins(1'b1, 1'b0, 1'b0, 1'b1, 1);
        wait_sts(1'b1, n);
        wait_sts(1'b0, n);
        rd_chk(32'h4, 32'h3E0);
        rd_chk(32'h0, 32'hC);
        w12 <= 1'b1;
        vin <= 12'h5A3;
        pins(1'b1, 1'b0, 1'b1, 1'b0, 8);
        db_chk(12'h3E0, 12'hFFF);
        pins(1'b1, 1'b0, 1'b0, 1'b0, 1);
        wait_sts(1'b1, n);
        chk(32'(n >= 3 && n <= 9), 32'h1);
        db_chk(12'h000, 12'h000);
        wait_sts(1'b0, n);
        repeat (4) @(posedge clk);
        db_chk(12'h000, 12'h000);
        pins(1'b1, 1'b0, 1'b1, 1'b0, 8);
        db_chk(12'h5A3, 12'hFFF);
        vin <= 12'h1B6;
        pins(1'b1, 1'b0, 1'b0, 1'b0, 6);
        pins(1'b1, 1'b0, 1'b1, 1'b0, 1);
        wait_sts(1'b1, n);
        db_chk(12'h000, 12'h000);
        n = 0;
        while (dboe === 12'h000 && n < 400) begin
            @(posedge clk);
            n++;
        end
        wait_sts(1'b0, n);
        chk(32'(n >= 9 && n <= 13), 32'h1);
        db_chk(12'h1B6, 12'hFFF);
        final_report();
    end

    // Tests need a few hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report();
    end
endmodule : tb
